/* File: rtl/fault_manager.sv */
// device end: fault supervision, protective actions and dead-time generation
//
// Contract
// - supply overvoltage latches flag, stops pump, disables outputs
// - supply overvoltage clear only after recovery
// - supply undervoltage sets flag, disables outputs, pump
// - undervoltage clear only after supply recovered
// - regulator input overvoltage sets flag, stops regulator
// - regulator overvoltage clear only after recovery
// - regulator input undervoltage warning flag, clear after recovery
// - regulator input power-on-reset resets everything
// - charge pump low sets flag, stops pump, outputs
// - pump failure cleared by command, then enable
// - regulator output warning flag, cleared by command
// - regulator output overvoltage sets failure, disables regulator
// - output low or start-up timeout latches failure
// - regulator stays off until failure flag cleared
// - logic supply reset holds registers at default
// - thermal warning sets latched flag
// - thermal shutdown disables bridges, pump, regulator
// - re-enable after cool, flag clear, then enable
// - dead time chosen from slew rate select
// - filtered overcurrent sets switch flag, disables outputs
// - host clears overcurrent before re-enabling outputs
// - open load timed per pwm cycle, flags only
`timescale 1ns/1ps
`default_nettype none
module fault_manager
   import fault_mgr_pkg::*;
#(
   parameter int STARTUP_TIMEOUT_CYCLES = `REG_TIMEOUT_CYC
)(
   input  wire logic           clk_in,
   input  wire logic           rst_in,
   fault_link_if.dev           link,
   input  wire ind_t           analog_ind_in,
   input  wire logic [`SW_N-1:0] oc_ind_in,
   input  wire logic           pwm_start_in,
   input  wire logic [1:0]     cur_reached_in,
   input  wire logic [3:0]     hb_cmd_in,
   output logic [3:0]          hs_on_out,
   output logic [3:0]          ls_on_out,
   output logic                charge_pump_on_out,
   output logic                regulator_on_out,
   output logic                motor_output_enable_out
);

   // ==========================================================
   // synchronisers
   localparam int SYN_W = `IND_W + `SW_N;
   logic [SYN_W-1:0] meta_q;
   logic [SYN_W-1:0] sync_q;
   ind_t             ind;
   logic [`SW_N-1:0] oc_s;

   // two flops per comparator line; first stage feeds only the second
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= {oc_ind_in, analog_ind_in};
         sync_q <= meta_q;
      end
   end
   assign ind  = sync_q[`IND_W-1:0];
   assign oc_s = sync_q[SYN_W-1:`IND_W];

   // either power-on-reset indication holds the whole core in reset
   logic core_rst;
   assign core_rst = rst_in | ind[`IND_VREG_POR] | ind[`IND_VDD_POR];

   // ==========================================================
   // latched flags
   logic [8:0]       gsr_q;
   logic [`SW_N-1:0] oc_q;
   logic [1:0]       ol_q;
   logic [`SW_N-1:0] oc_set;
   logic [1:0]       ol_set;
   logic             reg_fail_set;
   logic [8:0]       flag_set;
   logic [8:0]       clr_ok;

   // hardware events for each latched flag
   always_comb
   begin
      flag_set                = '0;
      flag_set[`GSR_VS_OV]    = ind[`IND_VS_OV];
      flag_set[`GSR_VS_UV]    = ind[`IND_VS_UV];
      flag_set[`GSR_VREG_OV]  = ind[`IND_VREG_OV];
      flag_set[`GSR_VREG_UV]  = ind[`IND_VREG_UV];
      flag_set[`GSR_CP_FAIL]  = ind[`IND_CP_LOW];
      flag_set[`GSR_V5_WARN]  = ind[`IND_V5_WARN];
      flag_set[`GSR_V5_FAIL]  = reg_fail_set;
      flag_set[`GSR_TW]       = ind[`IND_TW];
      flag_set[`GSR_TSD]      = ind[`IND_TSD];
   end

   // clears honoured only in the recovered state; others clear on command
   always_comb
   begin
      clr_ok                  = link.clr[8:0];
      clr_ok[`GSR_VS_OV]      = link.clr[`GSR_VS_OV] & ind[`IND_VS_OV_REC];
      clr_ok[`GSR_VS_UV]      = link.clr[`GSR_VS_UV] & ind[`IND_VS_UV_REC];
      clr_ok[`GSR_VREG_OV]    = link.clr[`GSR_VREG_OV] & ind[`IND_VREG_OV_REC];
      clr_ok[`GSR_VREG_UV]    = link.clr[`GSR_VREG_UV] & ind[`IND_VREG_UV_REC];
      clr_ok[`GSR_TSD]        = link.clr[`GSR_TSD] & ~ind[`IND_TSD];
   end

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (core_rst)
         gsr_q <= '0;
      else
         gsr_q <= (gsr_q & ~clr_ok) | flag_set;
   end

   always_ff @(posedge clk_in)
   begin
      if (core_rst)
         oc_q <= '0;
      else
         oc_q <= (oc_q & ~{`SW_N{link.clr[`GSR_OC]}}) | oc_set;
   end

   // phase flags go away through the summary clear
   always_ff @(posedge clk_in)
   begin
      if (core_rst)
         ol_q <= '0;
      else
         ol_q <= (ol_q & ~{2{link.clr[`GSR_OL]}}) | ol_set;
   end

   assign link.global_status_register = {|ol_q, |oc_q, gsr_q};
   assign link.motor_status_register = {ol_q, oc_q};

   // ==========================================================
   // motor output enable
   logic me_q;
   logic me_block;
   logic me_kill;
   assign me_block = gsr_q[`GSR_VS_OV] | gsr_q[`GSR_VS_UV] | gsr_q[`GSR_CP_FAIL] | gsr_q[`GSR_TSD] | (|oc_q);
   assign me_kill  = flag_set[`GSR_VS_OV] | flag_set[`GSR_VS_UV] | flag_set[`GSR_CP_FAIL]
                   | flag_set[`GSR_TSD] | (|oc_set);

   // a set request is ignored while any blocking flag is still latched
   always_ff @(posedge clk_in)
   begin
      if (core_rst)
         me_q <= 1'b0;
      else if (me_kill || link.me_clr)
         me_q <= 1'b0;
      else if (link.me_set && !me_block)
         me_q <= 1'b1;
   end
   assign link.me                 = me_q;
   assign motor_output_enable_out = me_q;

   // pump and regulator follow the latched flags
   assign charge_pump_on_out = ~(gsr_q[`GSR_VS_OV] | gsr_q[`GSR_VS_UV]
                               | gsr_q[`GSR_CP_FAIL] | gsr_q[`GSR_TSD]);
   assign regulator_on_out   = ~(gsr_q[`GSR_VREG_OV] | gsr_q[`GSR_V5_FAIL] | gsr_q[`GSR_TSD]);

   // ==========================================================
   // regulator start-up supervision
   logic        started_q;
   logic [19:0] start_cnt_q;
   logic        timed_out;
   assign timed_out    = (start_cnt_q == 20'(STARTUP_TIMEOUT_CYCLES));
   assign reg_fail_set = regulator_on_out & (ind[`IND_V5_OV]
                       | (started_q & ind[`IND_V5_LOW]) | (~started_q & timed_out));

   // timer restarts every time the regulator is switched back on
   always_ff @(posedge clk_in)
   begin
      if (core_rst || !regulator_on_out)
      begin
         started_q   <= 1'b0;
         start_cnt_q <= '0;
      end
      else if (!ind[`IND_V5_LOW])
         started_q <= 1'b1;
      else if (!started_q && !timed_out)
         start_cnt_q <= start_cnt_q + 20'h00001;
   end

   // ==========================================================
   // overcurrent filters, one per switch
   localparam logic [11:0] OC_CYC = 12'(`OC_FILTER_CYC);
   genvar gi;
   generate
      for (gi = 0; gi < `SW_N; gi++)
      begin : g_oc
         logic [11:0] cnt_q;
         // longer than the filter time means the count reaches the limit and holds there
         always_ff @(posedge clk_in)
         begin
            if (core_rst || !oc_s[gi])
               cnt_q <= '0;
            else if (cnt_q != OC_CYC)
               cnt_q <= cnt_q + 12'h001;
         end
         assign oc_set[gi] = oc_s[gi] & (cnt_q == OC_CYC);
      end
   endgenerate

   // ==========================================================
   // open load timing per phase
   function automatic logic [11:0] ol_cycles(input logic [1:0] sel);
      case (sel)
         2'h0:    ol_cycles = 12'(`NS2CYC(`OL_DLY0_NS));
         2'h1:    ol_cycles = 12'(`NS2CYC(`OL_DLY1_NS));
         2'h2:    ol_cycles = 12'(`NS2CYC(`OL_DLY2_NS));
         default: ol_cycles = 12'(`NS2CYC(`OL_DLY3_NS));
      endcase
   endfunction : ol_cycles

   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_ol
         logic [11:0] cnt_q;
         logic        run_q;
         // each pwm cycle start rearms; reaching the reference stops it
         always_ff @(posedge clk_in)
         begin
            if (core_rst)
            begin
               run_q <= 1'b0;
               cnt_q <= '0;
            end
            else if (pwm_start_in)
            begin
               run_q <= 1'b1;
               cnt_q <= '0;
            end
            else if (run_q && (cur_reached_in[gi] || ol_set[gi]))
               run_q <= 1'b0;
            else if (run_q)
               cnt_q <= cnt_q + 12'h001;
         end
         // drivers untouched: flag only
         assign ol_set[gi] = run_q & ~cur_reached_in[gi] & (cnt_q == ol_cycles(link.open_load_delay_select));
      end
   endgenerate

   // ==========================================================
   // dead-time generator, one per half bridge
   function automatic logic [7:0] dead_cycles(input logic [1:0] sr);
      case (sr)
         2'h0:    dead_cycles = 8'(`NS2CYC(`DT0_NS));
         2'h1:    dead_cycles = 8'(`NS2CYC(`DT1_NS));
         2'h2:    dead_cycles = 8'(`NS2CYC(`DT2_NS));
         default: dead_cycles = 8'(`NS2CYC(`DT3_NS));
      endcase
   endfunction : dead_cycles

   logic drive_ok;
   assign drive_ok = me_q & ~gsr_q[`GSR_TSD];

   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_hb
         hb_state_t st_q;
         hb_state_t want;
         logic [7:0] dt_q;
         assign want = !drive_ok ? HB_OFF : (hb_cmd_in[gi] ? HB_HS : HB_LS);
         // switching between sides always passes through a dead interval
         always_ff @(posedge clk_in)
         begin
            if (core_rst)
            begin
               st_q <= HB_OFF;
               dt_q <= '0;
            end
            else
            begin
               case (st_q)
                  HB_OFF:
                     st_q <= want;
                  HB_HS, HB_LS:
                     if (want != st_q)
                     begin
                        st_q <= HB_DEAD;
                        dt_q <= dead_cycles(link.sr);
                     end
                  HB_DEAD:
                     if (want == HB_OFF)
                        st_q <= HB_OFF;
                     else if (dt_q <= 8'h01)
                        st_q <= want;
                     else
                        dt_q <= dt_q - 8'h01;
                  default:
                     st_q <= HB_OFF;
               endcase
            end
         end
         assign hs_on_out[gi] = (st_q == HB_HS);
         assign ls_on_out[gi] = (st_q == HB_LS);
      end
   endgenerate

endmodule : fault_manager
`default_nettype wire

/* File: rtl/fault_mgr_cfg.svh */
// constants for the motor driver fault manager: flag positions, codes and timing
`ifndef FAULT_MGR_CFG_SVH
`define FAULT_MGR_CFG_SVH

// ==========================================================
// clock
`define CLK_MHZ            100

// ==========================================================
// global status flag positions
`define GSR_W              11
`define GSR_VS_OV          0
`define GSR_VS_UV          1
`define GSR_VREG_OV        2
`define GSR_VREG_UV        3
`define GSR_CP_FAIL        4
`define GSR_V5_WARN        5
`define GSR_V5_FAIL        6
`define GSR_TW             7
`define GSR_TSD            8
`define GSR_OC             9
`define GSR_OL             10

// ==========================================================
// motor status layout: eight switch overcurrent flags, then open load a/b
`define SW_N               8
`define MSR_W              10
`define MSR_OLA            8
`define MSR_OLB            9

// ==========================================================
// analog indication positions (synchronised inside the device)
`define IND_W              16
`define IND_VS_OV          0
`define IND_VS_OV_REC      1
`define IND_VS_UV          2
`define IND_VS_UV_REC      3
`define IND_VREG_OV        4
`define IND_VREG_OV_REC    5
`define IND_VREG_UV        6
`define IND_VREG_UV_REC    7
`define IND_VREG_POR       8
`define IND_VDD_POR        9
`define IND_CP_LOW         10
`define IND_V5_WARN        11
`define IND_V5_OV          12
`define IND_V5_LOW         13
`define IND_TW             14
`define IND_TSD            15

// ==========================================================
// timing: overcurrent filter (least time, rounded up)
`define OC_FILTER_NS       2000
`define OC_FILTER_CYC      ((`OC_FILTER_NS * `CLK_MHZ + 999) / 1000)
// open load delays per select code
`define OL_DLY0_NS         5000
`define OL_DLY1_NS         10000
`define OL_DLY2_NS         20000
`define OL_DLY3_NS         40000
`define NS2CYC(ns)         (((ns) * `CLK_MHZ) / 1000)
// dead times per slew rate code
`define DT0_NS             250
`define DT1_NS             500
`define DT2_NS             1000
`define DT3_NS             2000
// regulator start-up timeout
`define REG_TIMEOUT_US     1000
`define REG_TIMEOUT_CYC    (`REG_TIMEOUT_US * `CLK_MHZ)

// ==========================================================
// host register map (byte offsets) and fields
`define REG_GLOBAL_STATUS  8'h00
`define REG_MOTOR_STATUS   8'h04
`define REG_CLEAR          8'h08
`define REG_CONTROL        8'h0C
`define CTL_ME_BIT         0
`define CTL_REFUSED_BIT    1
`define CTL_SR_LSB         4
`define CTL_OPEN_LOAD_DELAY_SELECT_LSB      8
`define STAT_ME_BIT        16

`endif

/* File: rtl/fault_mgr_pkg.sv */
// types shared by both ends of the fault manager link
`include "fault_mgr_cfg.svh"
package fault_mgr_pkg;
   typedef logic [`GSR_W-1:0] gsr_t;
   typedef logic [`MSR_W-1:0] msr_t;
   typedef logic [`IND_W-1:0] ind_t;
   typedef enum logic [1:0] {HB_OFF, HB_DEAD, HB_HS, HB_LS} hb_state_t;
endpackage : fault_mgr_pkg

/* File: rtl/fault_link_if.sv */
// link between the fault manager and its controlling host
`timescale 1ns/1ps
`default_nettype none
interface fault_link_if;
   import fault_mgr_pkg::*;
   gsr_t        global_status_register;       // latched global flags
   msr_t        motor_status_register;       // switch overcurrent and open-load flags
   logic        me;        // motor output enable state
   gsr_t        clr;       // one-cycle clear requests per flag
   logic        me_set;    // one-cycle request to enable outputs
   logic        me_clr;    // one-cycle request to disable outputs
   logic [1:0]  sr;        // slew rate select
   logic [1:0]  open_load_delay_select;     // open load delay select

   modport dev  (output global_status_register, motor_status_register, me, input clr, me_set, me_clr, sr, open_load_delay_select);
   modport host (input global_status_register, motor_status_register, me, output clr, me_set, me_clr, sr, open_load_delay_select);
endinterface : fault_link_if
`default_nettype wire

/* File: rtl/fault_host.sv */
// host end: wishbone register front for clearing flags and enabling outputs
`timescale 1ns/1ps
`default_nettype none
module fault_host
   import fault_mgr_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   fault_link_if.host       link,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out
);

   // ==========================================================
   // bus slave
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        take;
   logic        wr;
   assign take       = wb_cyc_in & wb_stb_in & ~ack_q;
   // writes land on the edge at which the master samples ack, request still held
   assign wr         = wb_cyc_in & wb_stb_in & wb_we_in & ack_q;
   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdat_q;

   // one wait state; ack drops the cycle after it was given
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         ack_q <= 1'b0;
      else
         ack_q <= take;
   end

   // ==========================================================
   // control register
   logic       me_req_q;
   logic       refused_q;
   logic [1:0] sr_q;
   logic [1:0] open_load_delay_select_q;
   logic       blocked;
   logic       ctl_wr;
   assign ctl_wr  = wr & (wb_adr_in == `REG_CONTROL);
   // any latched outage flag must be cleared before asking for the outputs
   assign blocked = link.global_status_register[`GSR_VS_OV] | link.global_status_register[`GSR_VS_UV] | link.global_status_register[`GSR_CP_FAIL]
                  | link.global_status_register[`GSR_TSD] | link.global_status_register[`GSR_OC];

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         me_req_q  <= 1'b0;
         refused_q <= 1'b0;
         sr_q      <= '0;
         open_load_delay_select_q   <= '0;
      end
      else if (ctl_wr)
      begin
         if (wb_sel_in[0])
         begin
            me_req_q  <= wb_dat_in[`CTL_ME_BIT];
            refused_q <= wb_dat_in[`CTL_ME_BIT] & blocked;
            sr_q      <= wb_dat_in[`CTL_SR_LSB +: 2];
         end
         if (wb_sel_in[1])
            open_load_delay_select_q <= wb_dat_in[`CTL_OPEN_LOAD_DELAY_SELECT_LSB +: 2];
      end
   end

   // enable request pulses; a refused set is simply not forwarded
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         link.me_set <= 1'b0;
         link.me_clr <= 1'b0;
      end
      else
      begin
         link.me_set <= ctl_wr & wb_sel_in[0] & wb_dat_in[`CTL_ME_BIT] & ~blocked;
         link.me_clr <= ctl_wr & wb_sel_in[0] & ~wb_dat_in[`CTL_ME_BIT];
      end
   end
   assign link.sr    = sr_q;
   assign link.open_load_delay_select = open_load_delay_select_q;

   // ==========================================================
   // write-one-to-clear pulses towards the device
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         link.clr <= '0;
      else if (wr && (wb_adr_in == `REG_CLEAR))
         link.clr <= wb_dat_in[`GSR_W-1:0] & {{3{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
      else
         link.clr <= '0;
   end

   // ==========================================================
   // read mux, unmapped reads as zero
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         rdat_q <= '0;
      else if (take)
      begin
         case (wb_adr_in)
            `REG_GLOBAL_STATUS:
               rdat_q <= {15'h0000, link.me, 5'h00, link.global_status_register};
            `REG_MOTOR_STATUS:
               rdat_q <= {22'h000000, link.motor_status_register};
            `REG_CONTROL:
               rdat_q <= {22'h000000, open_load_delay_select_q, 2'h0, sr_q, 2'h0, refused_q, me_req_q};
            default:
               rdat_q <= 32'h00000000;
         endcase
      end
   end

endmodule : fault_host
`default_nettype wire

/* File: verification/fault_mgr_assertions.sv */
// concurrent checks on the link between the fault manager and its host
`timescale 1ns/1ps
`default_nettype none
`include "fault_mgr_cfg.svh"
module fault_mgr_assertions
   import fault_mgr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire gsr_t global_status_register,
   input wire msr_t motor_status_register,
   input wire logic me,
   input wire gsr_t clr,
   input wire logic me_set
);
   // ==========================================================
   // common clocking
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // flags that must keep the outputs off
   wire logic blk = global_status_register[`GSR_VS_OV] | global_status_register[`GSR_VS_UV] | global_status_register[`GSR_CP_FAIL] | global_status_register[`GSR_TSD] | global_status_register[`GSR_OC];

   // ==========================================================
   // protective actions
   AST_VS_OV_OFF: assert property ($rose(global_status_register[`GSR_VS_OV]) |-> !me)
      else $error("outputs on after supply overvoltage");
   AST_VS_UV_OFF: assert property ($rose(global_status_register[`GSR_VS_UV]) |-> !me)
      else $error("outputs on after supply undervoltage");
   AST_CP_OFF: assert property ($rose(global_status_register[`GSR_CP_FAIL]) |-> !me)
      else $error("outputs on after pump failure");
   AST_TSD_OFF: assert property ($rose(global_status_register[`GSR_TSD]) |-> !me)
      else $error("outputs on after thermal shutdown");
   AST_OC_OFF: assert property ($rose(|motor_status_register[7:0]) |-> global_status_register[`GSR_OC] && !me)
      else $error("switch overcurrent without summary or disable");
   AST_OL_SUM: assert property ($rose(|motor_status_register[9:8]) |-> global_status_register[`GSR_OL] && $stable(me))
      else $error("open load touched drivers or missed summary");
   // enabling needs a request and no blocking flag one cycle before
   AST_ME_GATE: assert property ($rose(me) |-> $past(me_set) && !$past(blk))
      else $error("outputs enabled while blocked");
   // a flag only drops on its clear request, or all drop together on power-on reset
   AST_NO_FALL: assert property (|(~global_status_register & $past(global_status_register) & ~$past(clr)) |-> global_status_register == '0 && !me)
      else $error("flag dropped without clear");

   // ==========================================================
   // coverage
   cover property ($rose(me));
   cover property ($rose(global_status_register[`GSR_TSD]));
   cover property ($fell(global_status_register[`GSR_VS_OV]));
endmodule : fault_mgr_assertions
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the fault manager and its wishbone host
`timescale 1ns/1ps
`default_nettype none
`include "fault_mgr_cfg.svh"
module tb;
   import fault_mgr_pkg::*;
   logic        clk_in, rst_in, cyc, stb, we, ack, pwm, cp_on, reg_on, me_out;
   logic [7:0]  adr, oc;
   logic [3:0]  sel, hb, hs, ls;
   logic [1:0]  cur;
   logic [31:0] wdat, rdat, q;
   ind_t        ind;
   int          n_errors, n_tests, cycles;

   // ==========================================================
   // design, link and checker
   fault_link_if link();
   fault_manager #(.STARTUP_TIMEOUT_CYCLES(50)) fault_manager_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link),
      .analog_ind_in(ind), .oc_ind_in(oc), .pwm_start_in(pwm), .cur_reached_in(cur), .hb_cmd_in(hb),
      .hs_on_out(hs), .ls_on_out(ls), .charge_pump_on_out(cp_on), .regulator_on_out(reg_on),
      .motor_output_enable_out(me_out));
   fault_host fault_host_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));
   fault_mgr_assertions fault_mgr_assertions_inst (.clk_in(clk_in), .rst_in(rst_in), .global_status_register(link.global_status_register),
      .motor_status_register(link.motor_status_register), .me(link.me), .clr(link.clr), .me_set(link.me_set));

   // ==========================================================
   // clock and hang guard
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         n_errors++;
         $display("[ERR] %0t run hung", $time);
         summarize();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic summarize();
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // classic cycle: hold until ack seen at an edge, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      do
         @(posedge clk_in);
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk(32'({cp_on, reg_on, me_out, hs, ls}), 32'h600);
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, `REG_GLOBAL_STATUS, 32'h0);
      chk(q, 32'h0);
   endtask : t_reset

   // each fault: latch, action, refused and accepted clears
   task automatic t_flags();
      int          ix[10] = '{0, 2, 4, 6, 10, 11, 12, 13, 14, 15};
      int          bt[10] = '{0, 1, 2, 3, 4, 5, 6, 6, 7, 8};
      logic [9:0]  pm     = 10'h213;
      logic [9:0]  rm     = 10'h2C4;
      logic [31:0] m;
      for (int i = 0; i < 10; i++)
      begin
         m = pm[i] ? 32'h0 : 32'h10000;
         wb(1'b1, `REG_CONTROL, 32'h1);
         ind[ix[i]] <= 1'b1;
         repeat (4) @(posedge clk_in);
         chk(32'({cp_on, reg_on, me_out}), 32'({~pm[i], ~rm[i], ~pm[i]}));
         wb(1'b1, `REG_CLEAR, 32'h1 << bt[i]);
         // long enough for a restarted regulator to run out its start-up time
         repeat (60) @(posedge clk_in);
         wb(1'b0, `REG_GLOBAL_STATUS, 32'h0);
         chk(q, (32'h1 << bt[i]) | m);
         ind[ix[i]] <= 1'b0;
         if (i < 4)
            ind[ix[i] + 1] <= 1'b0;
         repeat (4) @(posedge clk_in);
         chk(32'({cp_on, reg_on}), 32'({~pm[i], ~rm[i]}));
         wb(1'b1, `REG_CLEAR, 32'h1 << bt[i]);
         wb(1'b0, `REG_GLOBAL_STATUS, 32'h0);
         chk(q, (i < 4 ? 32'h1 << bt[i] : 32'h0) | m);
         if (i < 4)
            ind[ix[i] + 1] <= 1'b1;
         wb(1'b1, `REG_CLEAR, 32'h1 << bt[i]);
         wb(1'b1, `REG_CONTROL, 32'h1);
         wb(1'b0, `REG_GLOBAL_STATUS, 32'h0);
         chk(q, 32'h10000);
         chk(32'({cp_on, reg_on}), 32'h3);
      end
   endtask : t_flags

   task automatic t_oc();
      wb(1'b1, `REG_CONTROL, 32'h1);
      oc[3] <= 1'b1;
      repeat (150) @(posedge clk_in);
      chk(32'({link.motor_status_register, me_out}), 32'h1);
      repeat (60) @(posedge clk_in);
      chk(32'({link.motor_status_register, me_out}), 32'h10);
      oc[3] <= 1'b0;
      wb(1'b1, `REG_CONTROL, 32'h1);
      wb(1'b0, `REG_CONTROL, 32'h0);
      chk(32'({q[1], me_out}), 32'h2);
      wb(1'b1, `REG_CLEAR, 32'h200);
      wb(1'b1, `REG_CONTROL, 32'h1);
      wb(1'b0, `REG_MOTOR_STATUS, 32'h0);
      chk(32'({q[9:0], me_out}), 32'h1);
   endtask : t_oc

   // phase b reaches its reference, phase a never does
   task automatic t_ol();
      cur <= 2'b10;
      pwm <= 1'b1;
      @(posedge clk_in);
      pwm <= 1'b0;
      repeat (450) @(posedge clk_in);
      chk(32'({link.motor_status_register[9:8], me_out}), 32'h1);
      repeat (100) @(posedge clk_in);
      chk(32'({link.motor_status_register[9:8], me_out}), 32'h3);
      wb(1'b1, `REG_CLEAR, 32'h400);
      repeat (2) @(posedge clk_in);
      chk(32'(link.motor_status_register[9:8]), 32'h0);
   endtask : t_ol

   // low side to high side, gap measured for every slew code
   task automatic t_dead();
      int n;
      for (int s = 0; s < 4; s++)
      begin
         hb[0] <= 1'b0;
         wb(1'b1, `REG_CONTROL, 32'h1 | (s << 4));
         repeat (300) @(posedge clk_in);
         hb[0] <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_in);
            n++;
            chk(32'(hs & ls), 32'h0);
         end
         while (hs[0] !== 1'b1 && n < 400);
         chk(32'(n >= (25 << s) && n <= (25 << s) + 3), 32'h1);
      end
   endtask : t_dead

   // regulator input and logic supply resets
   task automatic t_por();
      for (int p = 8; p < 10; p++)
      begin
         ind[14] <= 1'b1;
         repeat (4) @(posedge clk_in);
         chk(32'(link.global_status_register[`GSR_TW]), 32'h1);
         ind[14] <= 1'b0;
         ind[p] <= 1'b1;
         repeat (6) @(posedge clk_in);
         chk(32'({link.global_status_register, me_out, hs, ls, cp_on, reg_on}), 32'h3);
         ind[p] <= 1'b0;
         repeat (4) @(posedge clk_in);
      end
   endtask : t_por

   // ==========================================================
   // main sequence
   initial
   begin
      {rst_in, cyc, stb, we, pwm, adr, oc, sel, hb, cur, wdat} = '0;
      rst_in = 1'b1;
      ind = 16'h00AA;
      n_errors = 0;
      n_tests = 0;
      cycles = 0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_flags();
      t_oc();
      t_ol();
      t_dead();
      t_por();
      summarize();
   end
endmodule : tb
`default_nettype wire
